// file: fmba_arbiter.sv
// Fixed-priority arbiter for four bus masters
// =====================================================
`include "fmba_defs.svh"

module fmba_arbiter (
  input  wire logic                         clk_in,    // Single-phase clock
  input  wire logic                         rst_b_in,  // Async reset, low
  input  wire fmba_pkg::fmba_bus_in_t       bus_in,    // Requests and lock
  output logic [`FMBA_NUM_MASTERS-1:0]      gnt_b_out  // Grants, active low
);
  import fmba_pkg::*;

  // =====================================================
  // Input synchronisers
  fmba_bus_in_t bus_s1;
  fmba_bus_in_t bus_s2;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_s1 <= '1;
      bus_s2 <= '1;
    end else begin
      bus_s1 <= bus_in;
      bus_s2 <= bus_s1;
    end
  end

  logic [`FMBA_NUM_MASTERS-1:0] req;
  logic                         locked;
  assign req    = ~bus_s2.req_b;
  assign locked = ~bus_s2.lock_b;

  // =====================================================
  // Priority encoding
  logic                   any_req;
  logic [`FMBA_IDX_W-1:0] top_idx;

  always_comb begin
    any_req = |req;
    top_idx = '0;
    for (int i = `FMBA_NUM_MASTERS - 1; i >= 0; i--) begin
      if (req[i]) begin
        top_idx = i[`FMBA_IDX_W-1:0];
      end
    end
  end

  // =====================================================
  // Grant state
  fmba_state_t            state;
  logic [`FMBA_IDX_W-1:0] owner;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= FMBA_IDLE;
      owner <= '0;
    end else begin
      case (state)
        FMBA_IDLE: begin
          if (any_req && !locked) begin
            state <= FMBA_OWNED;
            owner <= top_idx;
          end
        end
        FMBA_OWNED: begin
          if (any_req && top_idx < owner) begin
            state <= locked ? FMBA_WAIT_UNLOCK : FMBA_OWNED;
            if (!locked) begin
              owner <= top_idx;
            end
          end else if (!locked && !req[owner]) begin
            if (any_req) begin
              owner <= top_idx;
            end else begin
              state <= FMBA_IDLE;
            end
          end
        end
        FMBA_WAIT_UNLOCK: begin
          if (!locked) begin
            if (any_req) begin
              state <= FMBA_OWNED;
              owner <= top_idx;
            end else begin
              state <= FMBA_IDLE;
            end
          end
        end
        default: state <= FMBA_IDLE;
      endcase
    end
  end

  // =====================================================
  // Registered grant outputs
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gnt_b_out <= `FMBA_GNT_IDLE;
    end else begin
      gnt_b_out <= `FMBA_GNT_IDLE;
      if (state == FMBA_OWNED) begin
        gnt_b_out[owner] <= 1'b0;
      end
    end
  end

  // =====================================================
  // Checks
  // Requests from masters that outrank the present owner
  logic [`FMBA_NUM_MASTERS-1:0] outrank;

  for (genvar g = 0; g < `FMBA_NUM_MASTERS; g++) begin : g_outrank
    assign outrank[g] = req[g] && (g < owner);
  end

  // Owner still locked while a higher master asks
  sequence s_preempt_seen;
    state == FMBA_OWNED && locked && outrank != '0;
  endsequence

  // State gives up ownership, the pins follow one edge later
  sequence s_grant_dropped;
    state == FMBA_WAIT_UNLOCK ##1 gnt_b_out == `FMBA_GNT_IDLE;
  endsequence

  // State takes ownership, the owner's pin follows one edge later
  sequence s_granted;
    state == FMBA_OWNED ##1 !gnt_b_out[$past(owner)];
  endsequence

  property p_one_hot;
    @(posedge clk_in) disable iff (!rst_b_in)
      $countones(~gnt_b_out) <= 1;
  endproperty
  a_one_hot: assert property (p_one_hot) else $error("two grants");

  property p_no_switch_locked;
    @(posedge clk_in) disable iff (!rst_b_in)
      (locked && $past(locked) && gnt_b_out != `FMBA_GNT_IDLE)
      |=> (gnt_b_out == $past(gnt_b_out) ||
           gnt_b_out == `FMBA_GNT_IDLE);
  endproperty
  a_no_switch_locked: assert property (p_no_switch_locked)
    else $error("grant moved under lock");

  property p_new_grant_unlocked;
    @(posedge clk_in) disable iff (!rst_b_in)
      ($past(gnt_b_out) == `FMBA_GNT_IDLE &&
       gnt_b_out != `FMBA_GNT_IDLE) |-> !$past(locked, 2);
  endproperty
  a_new_grant_unlocked: assert property (p_new_grant_unlocked)
    else $error("grant issued under lock");

  property p_hold_locked;
    @(posedge clk_in) disable iff (!rst_b_in)
      (state == FMBA_OWNED && locked && $past(locked) &&
       gnt_b_out != `FMBA_GNT_IDLE) |=> gnt_b_out == $past(gnt_b_out);
  endproperty
  a_hold_locked: assert property (p_hold_locked)
    else $error("grant lost under lock");

  property p_preempt_drop;
    @(posedge clk_in) disable iff (!rst_b_in)
      s_preempt_seen |=> s_grant_dropped;
  endproperty
  a_preempt_drop: assert property (p_preempt_drop)
    else $error("grant not withdrawn");

  property p_wait_release;
    @(posedge clk_in) disable iff (!rst_b_in)
      (state == FMBA_WAIT_UNLOCK && locked) |=> state != FMBA_OWNED;
  endproperty
  a_wait_release: assert property (p_wait_release)
    else $error("granted before unlock");

  property p_wait_idle;
    @(posedge clk_in) disable iff (!rst_b_in)
      (state == FMBA_WAIT_UNLOCK && $past(state) == FMBA_WAIT_UNLOCK)
      |-> gnt_b_out == `FMBA_GNT_IDLE;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("grant while waiting");

  property p_release_grant;
    @(posedge clk_in) disable iff (!rst_b_in)
      (state == FMBA_WAIT_UNLOCK && !locked && outrank != '0)
      |=> owner < $past(owner) ##0 s_granted;
  endproperty
  a_release_grant: assert property (p_release_grant)
    else $error("higher master not granted");

  property p_idle_grants;
    @(posedge clk_in) disable iff (!rst_b_in)
      (state == FMBA_IDLE) |=> gnt_b_out == `FMBA_GNT_IDLE;
  endproperty
  a_idle_grants: assert property (p_idle_grants)
    else $error("grant while idle");

  property p_priority;
    @(posedge clk_in) disable iff (!rst_b_in)
      (state == FMBA_IDLE && any_req && !locked)
      |=> owner == $past(top_idx) ##0 s_granted;
  endproperty
  a_priority: assert property (p_priority)
    else $error("wrong master granted");

  property p_owner_on_top;
    @(posedge clk_in) disable iff (!rst_b_in)
      (state == FMBA_OWNED && !locked && outrank != '0)
      |=> owner < $past(owner);
  endproperty
  a_owner_on_top: assert property (p_owner_on_top)
    else $error("higher master not preferred");

endmodule

// file: fmba_defs.svh
// Constants for the four-master bus arbiter
`ifndef FMBA_DEFS_SVH
`define FMBA_DEFS_SVH

// =====================================================
// Sizes and reset values
`define FMBA_NUM_MASTERS 4
`define FMBA_IDX_W       2
`define FMBA_GNT_IDLE    4'hF

// =====================================================
// Timing
`define FMBA_CLK_PERIOD_NS 4
`define FMBA_MAX_DEV_MHZ   40

`endif

// file: fmba_pkg.sv
// Types for the four-master bus arbiter
`include "fmba_defs.svh"

package fmba_pkg;

  // Active-low request vector and lock line, bit i of req_b belongs to master i
  typedef struct packed {
    logic [`FMBA_NUM_MASTERS-1:0] req_b;
    logic                         lock_b;
  } fmba_bus_in_t;

  typedef enum logic [1:0] {
    FMBA_IDLE,
    FMBA_OWNED,
    FMBA_WAIT_UNLOCK
  } fmba_state_t;

endpackage

// file: fmba_masters.sv
// Behavioural model of the four bus masters
module fmba_masters (
  input  wire logic             clk_in,   // Clock
  input  wire logic [3:0]       want_in,  // Masters wanting the bus
  input  wire logic             hold_in,  // Owner keeps the bus locked
  output fmba_pkg::fmba_bus_in_t bus_out  // Requests and lock
);
  timeunit 1ns;
  timeprecision 1ps;
  import fmba_pkg::*;
  logic [3:0] req_lines = 4'hF;
  logic       lock_line = 1'b1;
  always @(posedge clk_in) begin
    req_lines <= ~want_in;
    lock_line <= ~hold_in;
  end
  assign bus_out = '{req_b: req_lines, lock_b: lock_line};
endmodule

// file: tb_fmba_arbiter.sv
// Self-checking testbench for the four-master bus arbiter
module tb_fmba_arbiter;
  timeunit 1ns;
  timeprecision 1ps;
  import fmba_pkg::*;
  logic         clk_in   = 1'b0;
  logic         rst_b_in = 1'b0;
  logic [3:0]   want     = 4'h0;
  logic         hold     = 1'b0;
  logic [3:0]   gnt_b;
  fmba_bus_in_t bus;
  int           miscompares  = 0;
  int           total_checks = 0;
  // ==========================================
  // Clock, masters and arbiter
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  fmba_masters masters (.clk_in(clk_in), .want_in(want), .hold_in(hold),
                        .bus_out(bus));
  fmba_arbiter dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus_in(bus),
                    .gnt_b_out(gnt_b));
  // ==========================================
  // Shared tasks
  task automatic check(input string what, input logic [3:0] seen,
                       input logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic drive(input logic [3:0] w, input logic h);
    @(posedge clk_in);
    want <= w;
    hold <= h;
  endtask
  task automatic await(input string what, input logic [3:0] exp);
    int n;
    n = 0;
    while (gnt_b !== exp && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    check(what, gnt_b, exp);
  endtask
  task automatic steady(input string what, input logic [3:0] exp,
                        input int n);
    repeat (n) begin
      @(negedge clk_in);
      check(what, gnt_b, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    want     <= 4'hF;
    hold     <= 1'b0;
    steady("gnt in reset", 4'hF, 2);
    drive(4'h0, 1'b0);
    steady("gnt in reset idle", 4'hF, 1);
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    steady("gnt idle", 4'hF, 8);
  endtask
  task automatic t_lock_idle;
    drive(4'h0, 1'b1);
    drive(4'h2, 1'b1);
    steady("gnt none under lock", 4'hF, 10);
    drive(4'h2, 1'b0);
    await("gnt after idle lock", 4'hD);
    drive(4'h0, 1'b1);
    steady("gnt kept under lock", 4'hD, 10);
    drive(4'h0, 1'b0);
    await("gnt freed", 4'hF);
  endtask
  task automatic t_priority;
    drive(4'hE, 1'b0);
    await("gnt lowest three", 4'hD);
    drive(4'hF, 1'b0);
    await("gnt all four", 4'hE);
    drive(4'h0, 1'b0);
    await("gnt none", 4'hF);
  endtask
  task automatic t_hold;
    drive(4'h4, 1'b0);
    await("gnt owner", 4'hB);
    drive(4'hC, 1'b1);
    steady("gnt lower under lock", 4'hB, 10);
    drive(4'h8, 1'b0);
    await("gnt after unlock", 4'h7);
  endtask
  task automatic t_preempt;
    drive(4'h4, 1'b0);
    await("gnt owner", 4'hB);
    drive(4'h5, 1'b1);
    await("gnt withdrawn", 4'hF);
    steady("gnt wait lock", 4'hF, 10);
    drive(4'h5, 1'b0);
    await("gnt higher", 4'hE);
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    t_reset();
    t_priority();
    t_lock_idle();
    t_hold();
    t_preempt();
    t_reset();
    give_verdict();
  end
  initial begin
    #20000;
    miscompares++;
    give_verdict();
  end
endmodule
